/* File: rtl/vsi_regs.svh */
// Purpose: Named constants for the voice store serial slave.
// Assumes: Included by bare name from the design files.
// Notes: The device id value is arbitrary.
`ifndef VSI_REGS_SVH
`define VSI_REGS_SVH
`define VSI_ADDR_FIXED 5'h10
`define VSI_BITS 4'h8
`define VSI_FN_STOP 3'h0
`define VSI_FN_PLAY 3'h5
`define VSI_FN_REC 3'h2
`define VSI_FN_DREAD 3'h4
`define VSI_FN_DWRITE 3'h1
`define VSI_RG_ADDR 3'h1
`define VSI_RG_CFG0 3'h2
`define VSI_RG_CFG1 3'h3
`define VSI_BLOCK_STEP 5'h01
`define VSI_GROUP_STEP 5'h04
`define VSI_LAST_GROUP 3'h7
`define VSI_LO_ZERO 5'h00
`define VSI_LAST_BYTE 3'h7
`define VSI_DEV_ID 4'h5
`define VSI_CFG_RESET 16'h0000
`define VSI_IDX_LAST 2'h3
`define VSI_IDX_HI 2'h1
`define VSI_IDX_LO 2'h2
`endif

/* File: rtl/vsi_pkg.sv */
// Purpose: Types shared by the voice store serial slave.
// Assumes: Nothing beyond the header of constants.
// Notes: State codes are left to the tools.
package vsi_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_STRETCH,
    ST_LOAD, ST_TX, ST_TX_ACK, ST_TX_ACKD, ST_SKIP
  } vsi_state_t;
  typedef enum logic [1:0] {
    TX_STATUS, TX_ADDR_HI, TX_ADDR_LO
  } vsi_txk_t;
endpackage

/* File: rtl/vsi_buf_if.sv */
// Purpose: Carrier between the serial core and the block buffers.
// Assumes: One clock for both ends.
// Notes: Byte side faces the bus, word side faces the array.
`timescale 1ns/1ps
interface vsi_buf_if;
  logic wr_mode;
  logic flush;
  logic byte_in_valid;
  logic [7:0] byte_in;
  logic byte_in_ready;
  logic [7:0] byte_out;
  logic byte_out_valid;
  logic byte_take;
  logic word_valid;
  logic [63:0] word;
  logic word_ready;
  logic word_in_valid;
  logic [63:0] word_in;
  logic word_in_ready;
  modport core (
    output wr_mode, flush, byte_in_valid, byte_in, byte_take,
    output word_ready, word_in_valid, word_in,
    input byte_in_ready, byte_out, byte_out_valid,
    input word_valid, word, word_in_ready
  );
  modport store (
    input wr_mode, flush, byte_in_valid, byte_in, byte_take,
    input word_ready, word_in_valid, word_in,
    output byte_in_ready, byte_out, byte_out_valid,
    output word_valid, word, word_in_ready
  );
endinterface

/* File: rtl/vsi_pin_sync.sv */
// Purpose: Three-stage synchroniser for pins from outside the clock.
// Assumes: Pins idle high.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ps
module vsi_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins in, clean levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & s3) | (q & (s2 ^ s3));
    end
  end
endmodule

/* File: rtl/vsi_dbuf.sv */
// Purpose: Two alternating 64-bit block buffers.
// Assumes: The core never fills and drains the same buffer at once.
// Notes: Serial side fills or drains one buffer while the other meets the array.
`timescale 1ns/1ps
`include "vsi_regs.svh"
module vsi_dbuf (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Buffer carrier
  vsi_buf_if.store b
);
  logic [63:0] mem [2];
  logic [1:0] full;
  logic fsel;
  logic dsel;
  logic [2:0] fcnt;
  logic [2:0] dcnt;
  logic push_b;
  logic pull_w;
  logic load_w;
  logic take_b;

  assign b.byte_in_ready = b.wr_mode & ~full[fsel];
  assign b.word_valid = b.wr_mode & full[dsel];
  assign b.word = mem[dsel];
  assign b.word_in_ready = ~b.wr_mode & ~full[fsel];
  assign b.byte_out_valid = ~b.wr_mode & full[dsel];
  assign b.byte_out = mem[dsel][63:56];
  assign push_b = b.byte_in_valid & b.byte_in_ready;
  assign pull_w = b.word_valid & b.word_ready;
  assign load_w = b.word_in_valid & b.word_in_ready;
  assign take_b = b.byte_take & b.byte_out_valid;

  always_ff @(posedge clk) begin
    if (srst || b.flush) begin
      full <= 2'h0;
      fsel <= 1'b0;
      dsel <= 1'b0;
      fcnt <= 3'h0;
      dcnt <= 3'h0;
    end else begin
      if (push_b) begin
        fcnt <= fcnt + 3'h1;
        if (fcnt == `VSI_LAST_BYTE) begin
          full[fsel] <= 1'b1;
          fsel <= ~fsel;
        end
      end
      if (load_w) begin
        full[fsel] <= 1'b1;
        fsel <= ~fsel;
      end
      if (pull_w) begin
        full[dsel] <= 1'b0;
        dsel <= ~dsel;
      end
      if (take_b) begin
        dcnt <= dcnt + 3'h1;
        if (dcnt == `VSI_LAST_BYTE) begin
          full[dsel] <= 1'b0;
          dsel <= ~dsel;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push_b) begin
      mem[fsel] <= {mem[fsel][55:0], b.byte_in};
    end else if (load_w) begin
      mem[fsel] <= b.word_in;
    end
    if (take_b) begin
      mem[dsel] <= {mem[dsel][55:0], 8'h00};
    end
  end
endmodule

/* File: rtl/vsi_i2c_slave.sv */
// Purpose: Two-wire slave and storage sequencer of a voice recorder.
// Assumes: Array, analog timebase and marker store sit outside.
// Notes: Open-drain pins drive low while their enable is high.
// Operation
// - Address 10000 plus two select pins.
// - First byte is address and direction.
// - Status read needs no command byte.
// - Read returns status, address high, address low; in digital read it returns buffer bytes.
// - Low address byte shows bits 4:0 zero.
// - STOP after status abandons address bytes.
// - Pages of 2048 bits, 11-bit page.
// - Digital page is thirty-two 64-bit blocks.
// - Write opcode fixes page content type.
// - Eight marker positions, every four blocks.
// - Stop finishes group of four blocks at the next group tick, then sets marker.
// - Playback marker raises the interrupt.
// - Recording starts on page boundary, or on the block of an address loaded with it.
// - Two alternating 64-bit write buffers.
// - Ack every byte, stretch clock when full.
// - Reads go through two 64-bit buffers.
// - Two 16-bit configuration registers.
// - Interrupt low until status read.
// - Row strobe low before page end.
`timescale 1ns/1ps
`include "vsi_regs.svh"
module vsi_i2c_slave #(
  parameter int PAGES = 2048
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps
  input wire logic addr_select_high_pin,
  input wire logic addr_select_low_pin,
  // Status pins
  output logic int_out,
  output logic int_oe,
  output logic row_boundary_strobe_out,
  output logic row_boundary_strobe_oe,
  // Array port
  output logic [15:0] arr_addr,
  output logic arr_wr_valid,
  output logic [63:0] arr_wr_data,
  input wire logic arr_wr_ready,
  output logic arr_page_digital,
  output logic arr_rd_req,
  input wire logic arr_rd_valid,
  input wire logic [63:0] arr_rd_data,
  output logic arr_eom_mark,
  // Analog timebase
  input wire logic group_tick,
  input wire logic eom_bit_in,
  output logic analog_record,
  output logic analog_play,
  // Configuration
  output logic [15:0] cfg0,
  output logic [15:0] cfg1
);
  localparam logic [11:0] PAGE_LIMIT = 12'(PAGES);

  vsi_pkg::vsi_state_t state;
  vsi_pkg::vsi_txk_t txk;
  vsi_buf_if bif ();
  logic [3:0] pins_q;
  logic scl;
  logic sda;
  logic scl_p;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic rw;
  logic [1:0] byte_idx;
  logic [7:0] cmd;
  logic [7:0] tmp_hi;
  logic [15:0] addr;
  logic zero_q;
  logic ovf;
  logic eom_hit;
  logic stop_pend;
  logic dig_wr;
  logic dig_rd;
  logic rx_fire;
  logic [7:0] op;
  logic exec;
  logic addr_load;
  logic cfg_load;
  logic stat_rd;
  logic [7:0] tx_byte;
  logic wr_go;
  logic rd_go;
  logic tick_run;
  logic [16:0] next_addr;
  logic addr_match;

  // Page and block step with range check past the last page.
  function automatic logic [16:0] vsi_step(
    input logic [15:0] a,
    input logic [4:0] inc
  );
    logic [5:0] b;
    logic [11:0] p;
    b = {1'b0, a[4:0]} + {1'b0, inc};
    p = {1'b0, a[15:5]} + {11'h000, b[5]};
    vsi_step = {(p >= PAGE_LIMIT), p[10:0], b[4:0]};
  endfunction

  vsi_pin_sync #(.W(4)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({scl_in, sda_in, addr_select_high_pin, addr_select_low_pin}),
    .q(pins_q)
  );

  vsi_dbuf u_buf (
    .clk(clk),
    .srst(srst),
    .b(bif)
  );

  assign scl = pins_q[3];
  assign sda = pins_q[2];
  assign scl_rise = scl & ~scl_p;
  assign scl_fall = ~scl & scl_p;
  assign start_c = scl & scl_p & sda_p & ~sda;
  assign stop_c = scl & scl_p & ~sda_p & sda;

  assign addr_match = (shreg[7:3] == `VSI_ADDR_FIXED)
    && (shreg[2:1] == pins_q[1:0]);
  assign rx_fire = (state == vsi_pkg::ST_RX) && scl_fall
    && (bitcnt == `VSI_BITS);
  assign op = (byte_idx == 2'h0) ? shreg : cmd;
  assign exec = rx_fire && (((byte_idx == 2'h0)
    && (shreg[2:0] != `VSI_RG_ADDR))
    || ((byte_idx == `VSI_IDX_LO) && (cmd[2:0] == `VSI_RG_ADDR)));
  assign addr_load = rx_fire && (byte_idx == `VSI_IDX_LO)
    && (cmd[2:0] == `VSI_RG_ADDR);
  assign cfg_load = rx_fire && (byte_idx == `VSI_IDX_LO)
    && ((cmd[2:0] == `VSI_RG_CFG0) || (cmd[2:0] == `VSI_RG_CFG1));
  assign stat_rd = (state == vsi_pkg::ST_LOAD) && ~dig_rd
    && (txk == vsi_pkg::TX_STATUS);

  always_comb begin
    unique case (txk)
      vsi_pkg::TX_STATUS:
        tx_byte = {eom_hit, ovf, analog_record | analog_play,
          dig_wr | dig_rd, `VSI_DEV_ID};
      vsi_pkg::TX_ADDR_HI: tx_byte = addr[15:8];
      vsi_pkg::TX_ADDR_LO: tx_byte = {addr[7:5], `VSI_LO_ZERO};
      default: tx_byte = 8'h00;
    endcase
  end

  assign bif.wr_mode = dig_wr;
  assign bif.flush = exec && op[6];
  assign bif.byte_in = shreg;
  assign bif.byte_in_valid = rx_fire && dig_wr
    && (byte_idx == `VSI_IDX_LAST || cmd[2:0] != `VSI_RG_ADDR)
    && (byte_idx != 2'h0);
  assign bif.byte_take = (state == vsi_pkg::ST_LOAD) && dig_rd
    && bif.byte_out_valid;
  assign wr_go = bif.word_valid && ~arr_wr_valid && ~ovf;
  // A buffer stays full until the array takes its word, so stalls stretch.
  assign bif.word_ready = arr_wr_valid && arr_wr_ready;
  assign rd_go = dig_rd && bif.word_in_ready && ~arr_rd_req && ~ovf;
  assign bif.word_in_valid = arr_rd_valid;
  assign bif.word_in = arr_rd_data;
  assign tick_run = group_tick && (analog_record || analog_play);
  assign next_addr = vsi_step(addr,
    tick_run ? `VSI_GROUP_STEP : `VSI_BLOCK_STEP);

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      zero_q <= 1'b0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      zero_q <= 1'b0;
    end
  end

  assign scl_out = zero_q;
  assign sda_out = zero_q;
  assign int_out = zero_q;
  assign row_boundary_strobe_out = zero_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= vsi_pkg::ST_IDLE;
      txk <= vsi_pkg::TX_STATUS;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (start_c) begin
      state <= vsi_pkg::ST_ADDR;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop_c) begin
      state <= vsi_pkg::ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      unique case (state)
        vsi_pkg::ST_IDLE, vsi_pkg::ST_SKIP: begin
          sda_oe <= 1'b0;
        end
        vsi_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `VSI_BITS) begin
            rw <= shreg[0];
            sda_oe <= addr_match;
            state <= addr_match ? vsi_pkg::ST_ADDR_ACK
              : vsi_pkg::ST_IDLE;
          end
        end
        vsi_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            txk <= vsi_pkg::TX_STATUS;
            sda_oe <= 1'b0;
            state <= rw ? vsi_pkg::ST_LOAD : vsi_pkg::ST_RX;
          end
        end
        vsi_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (rx_fire) begin
            sda_oe <= 1'b1;
            state <= vsi_pkg::ST_RX_ACK;
            if (byte_idx != `VSI_IDX_LAST) begin
              byte_idx <= byte_idx + 2'h1;
            end
          end
        end
        vsi_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            if (dig_wr && ~bif.byte_in_ready) begin
              scl_oe <= 1'b1;
              state <= vsi_pkg::ST_STRETCH;
            end else begin
              state <= vsi_pkg::ST_RX;
            end
          end
        end
        vsi_pkg::ST_STRETCH: begin
          if (bif.byte_in_ready) begin
            scl_oe <= 1'b0;
            state <= vsi_pkg::ST_RX;
          end
        end
        vsi_pkg::ST_LOAD: begin
          bitcnt <= 4'h0;
          if (~dig_rd) begin
            shreg <= tx_byte;
            sda_oe <= ~tx_byte[7];
            scl_oe <= 1'b0;
            state <= vsi_pkg::ST_TX;
            txk <= (txk == vsi_pkg::TX_ADDR_LO) ? vsi_pkg::TX_STATUS
              : vsi_pkg::vsi_txk_t'(txk + 2'h1);
          end else if (bif.byte_out_valid) begin
            shreg <= bif.byte_out;
            sda_oe <= ~bif.byte_out[7];
            scl_oe <= 1'b0;
            state <= vsi_pkg::ST_TX;
          end else begin
            scl_oe <= 1'b1;
          end
        end
        vsi_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == `VSI_BITS) begin
              sda_oe <= 1'b0;
              state <= vsi_pkg::ST_TX_ACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
        end
        vsi_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            state <= sda ? vsi_pkg::ST_SKIP : vsi_pkg::ST_TX_ACKD;
          end
        end
        vsi_pkg::ST_TX_ACKD: begin
          if (scl_fall) begin
            state <= vsi_pkg::ST_LOAD;
          end
        end
        default: begin
          state <= vsi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd <= 8'h00;
      tmp_hi <= 8'h00;
      cfg0 <= `VSI_CFG_RESET;
      cfg1 <= `VSI_CFG_RESET;
    end else if (rx_fire) begin
      if (byte_idx == 2'h0) begin
        cmd <= shreg;
      end
      if (byte_idx == `VSI_IDX_HI) begin
        tmp_hi <= shreg;
      end
      if (cfg_load && cmd[2:0] == `VSI_RG_CFG0) begin
        cfg0 <= {tmp_hi, shreg};
      end
      if (cfg_load && cmd[2:0] == `VSI_RG_CFG1) begin
        cfg1 <= {tmp_hi, shreg};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr <= 16'h0000;
    end else if (addr_load) begin
      addr <= {tmp_hi, shreg};
    end else if (exec && ~op[6] && op[5:3] == `VSI_FN_REC) begin
      addr[4:0] <= `VSI_LO_ZERO;
    end else if ((tick_run || wr_go || rd_go) && ~next_addr[16]) begin
      addr <= next_addr[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst || ovf) begin
      analog_record <= 1'b0;
      analog_play <= 1'b0;
      stop_pend <= 1'b0;
      dig_wr <= 1'b0;
      dig_rd <= 1'b0;
    end else if (exec) begin
      dig_wr <= op[6] && op[5:3] == `VSI_FN_DWRITE;
      dig_rd <= op[6] && op[5:3] == `VSI_FN_DREAD;
      analog_play <= ~op[6] && op[5:3] == `VSI_FN_PLAY;
      if (~op[6] && op[5:3] == `VSI_FN_REC) begin
        analog_record <= 1'b1;
        stop_pend <= 1'b0;
      end else if (~op[6] && analog_record) begin
        stop_pend <= 1'b1;
      end
    end else if (group_tick) begin
      if (stop_pend) begin
        analog_record <= 1'b0;
        stop_pend <= 1'b0;
      end
      if (analog_play && eom_bit_in) begin
        analog_play <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      eom_hit <= 1'b0;
      ovf <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      if (group_tick && analog_play && eom_bit_in) begin
        eom_hit <= 1'b1;
      end else if (stat_rd) begin
        eom_hit <= 1'b0;
      end
      if (((tick_run || wr_go || rd_go) && next_addr[16])
          || (addr_load && {1'b0, tmp_hi, shreg[7:5]} >= PAGE_LIMIT))
      begin
        ovf <= 1'b1;
      end else if (stat_rd) begin
        ovf <= 1'b0;
      end
      int_oe <= eom_hit | ovf;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      row_boundary_strobe_oe <= 1'b0;
    end else begin
      row_boundary_strobe_oe <= (analog_record || analog_play)
        && (addr[4:2] == `VSI_LAST_GROUP);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arr_addr <= 16'h0000;
      arr_wr_valid <= 1'b0;
      arr_wr_data <= 64'h0;
      arr_page_digital <= 1'b0;
      arr_rd_req <= 1'b0;
      arr_eom_mark <= 1'b0;
    end else begin
      arr_eom_mark <= 1'b0;
      if (analog_record || analog_play) begin
        arr_addr <= addr;
      end
      if (exec && op[5:3] == `VSI_FN_DWRITE && op[6]) begin
        arr_page_digital <= 1'b1;
      end else if (exec && op[5:3] == `VSI_FN_REC && ~op[6]) begin
        arr_page_digital <= 1'b0;
      end
      if (arr_wr_valid && arr_wr_ready) begin
        arr_wr_valid <= 1'b0;
      end else if (wr_go) begin
        arr_wr_valid <= 1'b1;
        arr_wr_data <= bif.word;
        arr_addr <= addr;
      end
      if (arr_rd_valid) begin
        arr_rd_req <= 1'b0;
      end else if (rd_go) begin
        arr_rd_req <= 1'b1;
        arr_addr <= addr;
      end
      if (group_tick && stop_pend && analog_record) begin
        arr_eom_mark <= 1'b1;
        arr_addr <= addr;
      end
    end
  end
endmodule

/* File: test/vsi_host_model.sv */
// Purpose: Host bus master model for the voice store serial slave.
// Assumes: Both lines pulled up; a high enable pulls a line low.
// Notes: Waits on a stretched clock are bounded; timeouts are counted in stalls.
`timescale 1ns/1ps
module vsi_host_model (
  // Clock
  input wire logic clk,
  // Line levels
  input wire logic scl,
  input wire logic sda,
  // Pull enables
  output logic scl_low,
  output logic sda_low
);
  int stalls = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hb(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rise();
    int k;
    k = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && k < 4000) begin
      hb(1);
      k++;
    end
    if (k == 4000) stalls++;
  endtask
  task automatic bit_io(input logic o, output logic i);
    hb(5);
    sda_low = ~o;
    hb(15);
    rise();
    hb(20);
    i = sda;
    scl_low = 1'b1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    hb(5);
    rise();
    hb(10);
    sda_low = 1'b1;
    hb(10);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    hb(5);
    sda_low = 1'b1;
    hb(15);
    rise();
    hb(10);
    sda_low = 1'b0;
    hb(20);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(b[i], x);
    bit_io(1'b1, x);
    ack = ~x;
  endtask
  task automatic rbyte(input logic give_ack, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, x);
      b[i] = x;
    end
    bit_io(~give_ack, x);
  endtask
endmodule

/* File: test/vsi_i2c_slave_assertions.sv */
// Purpose: Port checker for the voice store serial slave.
// Assumes: One clock domain, synchronous reset.
// Notes: Latencies follow the flop outputs of the design.
`timescale 1ns/1ps
module vsi_i2c_slave_assertions #(
  parameter int PAGES = 2048
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic row_boundary_strobe_oe,
  // Array port
  input wire logic [15:0] arr_addr,
  input wire logic arr_wr_valid,
  input wire logic [63:0] arr_wr_data,
  input wire logic arr_wr_ready,
  input wire logic arr_rd_req,
  input wire logic arr_rd_valid,
  input wire logic arr_eom_mark,
  // Timebase and modes
  input wire logic group_tick,
  input wire logic analog_record,
  input wire logic analog_play
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_wr_wait;
    arr_wr_valid && !arr_wr_ready;
  endsequence
  sequence s_rd_wait;
    arr_rd_req && !arr_rd_valid;
  endsequence
  a_pins_pull_low: assert property (!scl_out && !sda_out)
    else $error("open drain data not low");
  a_eom_after_tick: assert property (arr_eom_mark |->
    $past(group_tick && analog_record)) else $error("marker without tick");
  a_eom_single_end: assert property (arr_eom_mark |=>
    !arr_eom_mark && !analog_record) else $error("marker or record stays");
  a_mark_not_play: assert property (analog_play |-> !arr_eom_mark)
    else $error("marker written in playback");
  a_wr_held: assert property (s_wr_wait |=> arr_wr_valid &&
    $stable(arr_wr_data) && $stable(arr_addr)) else $error("write dropped");
  a_rd_held: assert property (s_rd_wait |=> arr_rd_req &&
    $stable(arr_addr)) else $error("read request dropped");
  a_strobe_last_group: assert property (row_boundary_strobe_oe |->
    (arr_addr[4:2] == 3'h7 || $past(arr_addr[4:2]) == 3'h7))
    else $error("row strobe outside last group");
  a_modes_exclusive: assert property (!(analog_record && analog_play))
    else $error("record and play together");
endmodule
bind vsi_i2c_slave vsi_i2c_slave_assertions #(.PAGES(PAGES)) u_assert (
  .clk(clk), .srst(srst), .scl_out(scl_out), .sda_out(sda_out),
  .row_boundary_strobe_oe(row_boundary_strobe_oe), .arr_addr(arr_addr),
  .arr_wr_valid(arr_wr_valid), .arr_wr_data(arr_wr_data),
  .arr_wr_ready(arr_wr_ready), .arr_rd_req(arr_rd_req),
  .arr_rd_valid(arr_rd_valid), .arr_eom_mark(arr_eom_mark),
  .group_tick(group_tick), .analog_record(analog_record),
  .analog_play(analog_play));

/* File: test/voice_store_i2c_slave_tb_top.sv */
// Purpose: Self-checking bench for the voice store serial slave.
// Assumes: Host model on the bus; the array is answered here.
// Notes: Page count cut to 256; the array stalls writes on demand.
`timescale 1ns/1ps
module voice_store_i2c_slave_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] pins = 2'h0;
  logic arr_wr_ready = 1'b0;
  logic arr_rd_valid = 1'b0;
  logic group_tick = 1'b0;
  logic eom_bit_in = 1'b0;
  logic hold_wr = 1'b0;
  logic [7:0] dev = 8'h80;
  logic scl_out, scl_oe, sda_out, sda_oe, int_out, int_oe, rbs_out, rbs_oe;
  logic wr_v, pg_dig, rd_req, eom_mark, a_rec, a_play, m_scl, m_sda;
  logic [15:0] arr_addr, cfg0, cfg1;
  logic [63:0] wr_data;
  logic [63:0] wq[$];
  logic [15:0] aq[$];
  int mismatches = 0;
  int n_compared = 0;
  wire scl = ~(m_scl | scl_oe);
  wire sda = ~(m_sda | sda_oe);
  always #50 clk = ~clk;
  vsi_host_model host (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda));
  vsi_i2c_slave #(.PAGES(256)) dut (.clk(clk), .srst(srst), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_high_pin(pins[1]),
    .addr_select_low_pin(pins[0]), .int_out(int_out), .int_oe(int_oe),
    .row_boundary_strobe_out(rbs_out), .row_boundary_strobe_oe(rbs_oe),
    .arr_addr(arr_addr), .arr_wr_valid(wr_v), .arr_wr_data(wr_data),
    .arr_wr_ready(arr_wr_ready), .arr_page_digital(pg_dig),
    .arr_rd_req(rd_req), .arr_rd_valid(arr_rd_valid),
    .arr_rd_data(64'hfedcba9876543210), .arr_eom_mark(eom_mark),
    .group_tick(group_tick), .eom_bit_in(eom_bit_in),
    .analog_record(a_rec), .analog_play(a_play), .cfg0(cfg0), .cfg1(cfg1));
  // Writes can be held off to fill both buffers.
  always @(negedge clk) begin
    arr_wr_ready <= wr_v & ~hold_wr;
    arr_rd_valid <= rd_req & ~arr_rd_valid;
  end
  always @(posedge clk) begin
    if (wr_v && arr_wr_ready) begin
      wq.push_back(wr_data);
      aq.push_back(arr_addr);
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    mismatches += host.stalls;
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    logic a;
    host.wbyte(b, a);
    check(a, 1'b1);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] v, input bit two);
    host.start();
    send(dev);
    send(c);
    if (two) begin
      send(v[15:8]);
      send(v[7:0]);
    end
    host.stop();
  endtask
  task automatic rd3(input bit full, output logic [7:0] s, h, l);
    host.start();
    send(dev | 8'h01);
    host.rbyte(full, s);
    if (full) begin
      host.rbyte(1'b1, h);
      host.rbyte(1'b0, l);
    end
    host.stop();
  endtask
  task automatic tick(input logic end_of_message_marker, output logic mark);
    mark = 1'b0;
    eom_bit_in = end_of_message_marker;
    group_tick = 1'b1;
    repeat (6) begin
      @(negedge clk);
      group_tick = 1'b0;
      if (eom_mark === 1'b1) mark = 1'b1;
    end
  endtask
  task automatic t_address();
    logic a;
    for (int p = 0; p < 4; p++) begin
      pins = p[1:0];
      dev = {5'h10, p[1:0], 1'b0};
      host.hb(10);
      host.start();
      host.wbyte(dev ^ 8'h02, a);
      check(a, 1'b0);
      host.stop();
      cmd(8'h80, 16'h0000, 1'b0);
    end
  endtask
  task automatic t_regs();
    logic [7:0] s, h, l;
    cmd(8'h82, 16'ha5c3, 1'b1);
    cmd(8'h83, 16'h3c5a, 1'b1);
    check({cfg0, cfg1}, 32'ha5c33c5a);
    cmd(8'ha9, 16'h12ff, 1'b1);
    check({a_play, rbs_oe}, 2'h3);
    cmd(8'h80, 16'h0000, 1'b0);
    rd3(1'b1, s, h, l);
    check(s & 8'hdf, 8'h05);
    check({h, l}, 16'h12e0);
  endtask
  task automatic t_play();
    logic [7:0] s, h, l;
    logic m;
    cmd(8'ha8, 16'h0000, 1'b0);
    tick(1'b1, m);
    check(int_oe, 1'b1);
    rd3(1'b0, s, h, l);
    check({s & 8'h8f, int_oe}, 9'h10a);
    rd3(1'b1, s, h, l);
    check(s & 8'h4f, 8'h05);
    cmd(8'h80, 16'h0000, 1'b0);
  endtask
  task automatic t_record();
    logic m;
    logic [7:0] s, h, l;
    cmd(8'h90, 16'h0000, 1'b0);
    cmd(8'h80, 16'h0000, 1'b0);
    check({a_rec, pg_dig}, 2'h2);
    tick(1'b0, m);
    check({m, a_rec}, 2'h2);
    cmd(8'h91, 16'h2000, 1'b1);
    check({int_oe, a_rec}, 2'h2);
    rd3(1'b0, s, h, l);
    check(s, 8'h45);
  endtask
  task automatic t_digital();
    logic [7:0] s, h, l;
    hold_wr = 1'b1;
    host.start();
    send(dev);
    send(8'hc9);
    send(8'h00);
    send(8'h40);
    for (int i = 0; i < 16; i++) send(8'(i * 17));
    fork
      host.stop();
      begin
        host.hb(1500);
        check(scl_oe, 1'b1);
        hold_wr = 1'b0;
      end
    join
    for (int k = 0; k < 400 && wq.size() < 2; k++) @(negedge clk);
    check(wq.size(), 2);
    check(wq[0], 64'h0011223344556677);
    check(wq[1], 64'h8899aabbccddeeff);
    check({aq[0], aq[1], pg_dig}, 33'h000800083);
    cmd(8'he1, 16'h0040, 1'b1);
    rd3(1'b0, s, h, l);
    check(s, 8'hfe);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (10) @(negedge clk);
    check({cfg0, cfg1, arr_addr, sda_oe, scl_oe, int_oe}, 51'h0);
    check({int_out, rbs_out, sda_out, scl_out}, 4'h0);
    t_address();
    t_regs();
    t_play();
    t_record();
    t_digital();
    conclude();
  end
endmodule
